// ---- msps_regs.svh ----
/*
 Register map, field positions, reset values and range limits of the
 multi-segment position sequencer. Assumes an 8-bit AXI4-Lite byte address.
*/
`ifndef MSPS_REGS_SVH
`define MSPS_REGS_SVH

`define MSPS_OFF_POS       8'h00
`define MSPS_OFF_SPEED     8'h04
`define MSPS_OFF_RAMP      8'h08
`define MSPS_OFF_IDLE      8'h0c
`define MSPS_OFF_DECEL1    8'h10
`define MSPS_OFF_DECEL2    8'h14
`define MSPS_OFF_TRIG      8'h18
`define MSPS_OFF_NEXT      8'h1c
`define MSPS_OFF_SRC       8'h20
`define MSPS_OFF_CTRL      8'h24
`define MSPS_OFF_STATUS    8'h28

`define MSPS_NUM_HALF      8
`define MSPS_IDX_SPEED     0
`define MSPS_IDX_RAMP      1
`define MSPS_IDX_IDLE      2
`define MSPS_IDX_DECEL1    3
`define MSPS_IDX_DECEL2    4
`define MSPS_IDX_TRIG      5
`define MSPS_IDX_NEXT      6
`define MSPS_IDX_SRC       7

`define MSPS_RST_POS       32'h0000_2710
`define MSPS_RST_SPEED     16'h01f4
`define MSPS_RST_RAMP      16'h01f4
`define MSPS_RST_IDLE      16'h0001
`define MSPS_RST_DECEL     16'h01f4
`define MSPS_RST_TRIG      16'h0001
`define MSPS_RST_NEXT      16'h0000
`define MSPS_RST_SRC       16'h0000
`define MSPS_RST_LAST_SEG  4'hf

`define MSPS_POS_MAX       32'h7fff_ffff
`define MSPS_POS_MIN       32'h8000_0001
`define MSPS_MAX_SPEED     16'h7fff
`define MSPS_MAX_MS        16'hffff
`define MSPS_MAX_IDLE      16'h7fff
`define MSPS_MAX_TRIG      16'h0003
`define MSPS_MAX_NEXT      16'h0001
`define MSPS_MAX_SRC       16'h0004

`define MSPS_TRIG_STOP_BIT 0
`define MSPS_TRIG_AUTO_BIT 1
`define MSPS_CTRL_MODE_BIT 0
`define MSPS_CTRL_LAST_LSB 4
`define MSPS_STAT_BUSY_BIT 0
`define MSPS_STAT_TRIG_BIT 1
`define MSPS_STAT_ST_LSB   2
`define MSPS_STAT_SEG_LSB  4
`define MSPS_STAT_DSEL_LSB 8
`define MSPS_LAST_SEG      4'hf

`endif

// ---- msps_pkg.sv ----
/*
 Types of the multi-segment position sequencer.
 Assumes msps_regs.svh supplies the numeric constants.
*/
`default_nettype none
package msps_pkg;
   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT_DONE, SQ_DWELL} msps_state_t;
   typedef enum logic [2:0] {
      SRC_STORED, SRC_ANALOG_ONE, SRC_ANALOG_TWO, SRC_ANALOG_THREE, SRC_PULSE_RATE
   } msps_src_t;
   typedef struct packed {
      logic        valid;
      logic        first;
      logic [3:0]  segment;
      logic [31:0] position;
      logic [15:0] speed;
      logic [15:0] ramp;
   } msps_cmd_t;
   typedef struct packed {
      logic [15:0] stored_first_speed;
      logic [15:0] analog_input_one;
      logic [15:0] analog_input_two;
      logic [15:0] analog_input_three;
      logic [15:0] pulse_rate;
   } msps_speed_in_t;
endpackage : msps_pkg
`default_nettype wire

// ---- msps_sync.sv ----
/*
 Two-stage synchroniser for pin inputs, width set by a parameter.
 Assumes a free-running aclk and an enable that freezes it.
*/
`timescale 1ns/100ps
`default_nettype none
module msps_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } msps_sync_state_t;

   msps_sync_state_t s_q;
   msps_sync_state_t s_d;

   always_comb begin
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;
endmodule : msps_sync
`default_nettype wire

// ---- msps_range_limit.sv ----
/*
 Saturating limiter: an unsigned write value above MAX becomes MAX.
 Assumes the caller has already merged byte strobes into value_in.
*/
`timescale 1ns/100ps
`default_nettype none
module msps_range_limit #(
   parameter logic [15:0] MAX = 16'hffff
) (
   input  wire logic [31:0] value_in,
   output logic      [15:0] value_out
);
   assign value_out = (value_in > {16'h0000, MAX}) ? MAX : value_in[15:0];
endmodule : msps_range_limit
`default_nettype wire

// ---- msps_sequencer.sv ----
/*
 Multi-segment position sequencer: segment-sixteen settings, deceleration
 times, trigger handling and command issue, with an AXI4-Lite register slave.
 Assumes motion logic on aclk consumes cmd pulses and reports segment_done,
 and a time base on aclk supplies one idle tick per idle time unit.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
// Contract
// R1 - Segment sixteen position is signed, limited to +/-2147483647, reset 10000.
// R2 - Segment sixteen ramp time in ms takes 0 to 65535, reset 500.
// R3 - Segment sixteen idle time takes 0 to 32767, reset 1, counted in external units.
// R4 - Trigger type is two bits, 0 to 3, reset 1, effective at once.
// R5 - With stop select 0 a trigger rise starts and a trigger fall stops the sequence.
// R6 - With stop select 1 a trigger rise starts and a fall does not stop.
// R7 - With autostart select 0 and digital selection, an input change starts that segment.
// R8 - With autostart select 1 input changes start nothing; only a new trigger rise does.
// R9 - Next command waits for completion then idle time (0), or idle time after issue (1).
// R10 - First command speed comes from stored, analog one, two, three (unsupported) or pulses.
// R11 - Segment sixteen speed in rpm takes 0 to 32767, reset 500, effective at once.
// R12 - Two deceleration times in ms take 0 to 65535 each, reset 500, effective at once.
`timescale 1ns/100ps
`default_nettype none
`include "msps_regs.svh"
module msps_sequencer (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    sequence_trigger_input,
   input  wire logic [3:0]              digital_select_inputs,
   input  wire msps_pkg::msps_speed_in_t speed_in,
   input  wire logic                    segment_done,
   input  wire logic                    idle_time_unit_tick,
   input  wire logic [15:0]             ext_idle_time,
   output msps_pkg::msps_cmd_t          cmd,
   output logic                         seq_busy,
   output logic                         seq_halt,
   output logic                         seq_finish,
   output logic [15:0]                  first_decel_time,
   output logic [15:0]                  second_decel_time
);
   import msps_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] FMAX [`MSPS_NUM_HALF] = '{
      `MSPS_MAX_SPEED, `MSPS_MAX_MS, `MSPS_MAX_IDLE, `MSPS_MAX_MS,
      `MSPS_MAX_MS, `MSPS_MAX_TRIG, `MSPS_MAX_NEXT, `MSPS_MAX_SRC
   };

   typedef struct packed {
      logic                            awready;
      logic                            wready;
      logic                            arready;
      logic                            aw_held;
      logic                            w_held;
      logic [7:0]                      awaddr;
      logic [31:0]                     wdata;
      logic [3:0]                      wstrb;
      logic                            bvalid;
      logic [1:0]                      bresp;
      logic                            rvalid;
      logic [31:0]                     rdata;
      logic [1:0]                      rresp;
      logic [31:0]                     pos;
      logic [`MSPS_NUM_HALF-1:0][15:0] regs;
      logic                            dsel_mode;
      logic [3:0]                      last_seg;
      logic                            trig_prev;
      logic [3:0]                      dsel_prev;
      msps_state_t                     state;
      logic [3:0]                      seg;
      logic                            first;
      logic [15:0]                     idle_cnt;
      msps_cmd_t                       cmd;
      logic                            halt;
      logic                            finish;
      logic                            busy;
   } msps_top_state_t;

   msps_top_state_t s_q;
   msps_top_state_t s_d;

   logic        trig_s;
   logic [3:0]  dsel_s;
   logic [31:0] merged [`MSPS_NUM_HALF];
   logic [15:0] limited [`MSPS_NUM_HALF];
   logic [31:0] pos_merged;

   // Pins are asynchronous to aclk
   msps_sync #(.W(1)) u_trig_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .async_in (sequence_trigger_input),
      .sync_out (trig_s)
   );

   msps_sync #(.W(4)) u_dsel_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .async_in (digital_select_inputs),
      .sync_out (dsel_s)
   );

   function automatic logic [31:0] strobe_merge(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : strobe_merge

   always_comb begin
      for (int i = 0; i < `MSPS_NUM_HALF; i++) begin
         merged[i] = strobe_merge({16'h0000, s_q.regs[i]}, s_q.wdata, s_q.wstrb);
      end
      pos_merged = strobe_merge(s_q.pos, s_q.wdata, s_q.wstrb);
   end

   // Out-of-range writes saturate rather than being refused
   for (genvar g = 0; g < `MSPS_NUM_HALF; g++) begin : g_limit
      msps_range_limit #(.MAX(FMAX[g])) u_limit (
         .value_in  (merged[g]),
         .value_out (limited[g])
      ); // R2 R3 R4 R11 R12
   end

   function automatic logic [15:0] first_speed(input logic [15:0]    src,
                                               input msps_speed_in_t sp);
      logic [15:0] v;
      v = 16'h0000;
      unique case (src[2:0])
         SRC_STORED:       v = sp.stored_first_speed;
         SRC_ANALOG_ONE:   v = sp.analog_input_one;
         SRC_ANALOG_TWO:   v = sp.analog_input_two;
         SRC_ANALOG_THREE: v = 16'h0000; // No converter behind this input
         SRC_PULSE_RATE:   v = sp.pulse_rate;
         default:          v = 16'h0000;
      endcase
      return v; // R10
   endfunction : first_speed

   always_comb begin
      logic [7:0]  ra;
      logic [7:0]  wa;
      logic        hit;
      logic        rise;
      logic        fall;
      logic        dchg;
      logic        start;
      logic        stop;
      logic        is_last;
      ra      = {s_axi_araddr[7:2], 2'b00};
      wa      = {s_q.awaddr[7:2], 2'b00};
      hit     = 1'b0;
      // Trigger edges and input changes, seen after synchronisation
      rise  = trig_s && !s_q.trig_prev;
      fall  = !trig_s && s_q.trig_prev;
      dchg  = dsel_s != s_q.dsel_prev;
      start = rise // R5 R6 R8
            || (s_q.dsel_mode && !s_q.regs[`MSPS_IDX_TRIG][`MSPS_TRIG_AUTO_BIT] && dchg); // R7
      stop  = fall && !s_q.regs[`MSPS_IDX_TRIG][`MSPS_TRIG_STOP_BIT]; // R5 R6
      is_last = s_q.dsel_mode || (s_q.seg == s_q.last_seg);
      s_d     = s_q;
      s_d.cmd.valid = 1'b0;
      s_d.halt      = 1'b0;
      s_d.finish    = 1'b0;
      s_d.busy      = s_q.state != SQ_IDLE;

      // Address and data are taken in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_held = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_held = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
         if (wa == `MSPS_OFF_POS) begin
            hit = 1'b1;
            // The lone code below the symmetric range saturates
            s_d.pos = (pos_merged == 32'h8000_0000) ? `MSPS_POS_MIN : pos_merged; // R1
         end
         for (int i = 0; i < `MSPS_NUM_HALF; i++) begin
            if (wa == `MSPS_OFF_SPEED + 8'(4 * i)) begin
               hit         = 1'b1;
               s_d.regs[i] = limited[i]; // R2 R3 R4 R9 R10 R11 R12
            end
         end
         if (wa == `MSPS_OFF_CTRL) begin
            hit           = 1'b1;
            s_d.dsel_mode = pos_merged[`MSPS_CTRL_MODE_BIT];
            s_d.last_seg  = pos_merged[`MSPS_CTRL_LAST_LSB +: 4];
         end
         if (wa == `MSPS_OFF_STATUS) begin
            hit = 1'b1;
         end
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
      end
      s_d.awready = !s_d.aw_held && !s_d.bvalid;
      s_d.wready  = !s_d.w_held && !s_d.bvalid;

      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         s_d.rdata  = 32'h0000_0000;
         unique case (ra)
            `MSPS_OFF_POS:    s_d.rdata = s_q.pos;
            `MSPS_OFF_CTRL: begin
               s_d.rdata[`MSPS_CTRL_MODE_BIT]        = s_q.dsel_mode;
               s_d.rdata[`MSPS_CTRL_LAST_LSB +: 4]   = s_q.last_seg;
            end
            `MSPS_OFF_STATUS: begin
               s_d.rdata[`MSPS_STAT_BUSY_BIT]        = s_q.state != SQ_IDLE;
               s_d.rdata[`MSPS_STAT_TRIG_BIT]        = trig_s;
               s_d.rdata[`MSPS_STAT_ST_LSB +: 2]     = s_q.state;
               s_d.rdata[`MSPS_STAT_SEG_LSB +: 4]    = s_q.seg;
               s_d.rdata[`MSPS_STAT_DSEL_LSB +: 4]   = dsel_s;
            end
            default: begin
               s_d.rresp = RESP_SLVERR;
               for (int i = 0; i < `MSPS_NUM_HALF; i++) begin
                  if (ra == `MSPS_OFF_SPEED + 8'(4 * i)) begin
                     s_d.rresp = RESP_OKAY;
                     s_d.rdata = {16'h0000, s_q.regs[i]};
                  end
               end
            end
         endcase
      end
      s_d.arready = !s_d.rvalid;

      s_d.trig_prev = trig_s;
      s_d.dsel_prev = dsel_s;

      // Stop outranks a simultaneous input-change start
      if (stop) begin
         if (s_q.state != SQ_IDLE) begin
            s_d.halt = 1'b1;
         end
         s_d.state = SQ_IDLE; // R5
      end else if (start) begin
         s_d.seg   = s_q.dsel_mode ? dsel_s : 4'h0;
         s_d.first = 1'b1;
         s_d.state = SQ_ISSUE;
      end else begin
         unique case (s_q.state)
            SQ_IDLE: begin
            end
            SQ_ISSUE: begin
               s_d.cmd.valid    = 1'b1;
               s_d.cmd.first    = s_q.first;
               s_d.cmd.segment  = s_q.seg;
               s_d.cmd.position = (s_q.seg == `MSPS_LAST_SEG) ? s_q.pos : 32'h0000_0000; // R1
               s_d.cmd.ramp     = (s_q.seg == `MSPS_LAST_SEG) ?
                                  s_q.regs[`MSPS_IDX_RAMP] : 16'h0000; // R2
               if (s_q.first) begin
                  s_d.cmd.speed = first_speed(s_q.regs[`MSPS_IDX_SRC], speed_in); // R10
               end else begin
                  s_d.cmd.speed = (s_q.seg == `MSPS_LAST_SEG) ?
                                  s_q.regs[`MSPS_IDX_SPEED] : 16'h0000; // R11
               end
               s_d.idle_cnt = (s_q.seg == `MSPS_LAST_SEG) ?
                              s_q.regs[`MSPS_IDX_IDLE] : ext_idle_time; // R3
               s_d.state = s_q.regs[`MSPS_IDX_NEXT][0] ? SQ_DWELL : SQ_WAIT_DONE; // R9
            end
            SQ_WAIT_DONE: begin
               if (segment_done) begin
                  s_d.state = SQ_DWELL; // R9
               end
            end
            SQ_DWELL: begin
               if (s_q.idle_cnt == 16'h0000) begin
                  if (is_last) begin
                     s_d.finish = 1'b1;
                     s_d.state  = SQ_IDLE;
                  end else begin
                     s_d.seg   = s_q.seg + 4'h1;
                     s_d.first = 1'b0;
                     s_d.state = SQ_ISSUE;
                  end
               end else if (idle_time_unit_tick) begin
                  s_d.idle_cnt = s_q.idle_cnt - 16'h0001; // R3 R9
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q                          <= '0;
         s_q.pos                      <= `MSPS_RST_POS; // R1
         s_q.regs[`MSPS_IDX_SPEED]    <= `MSPS_RST_SPEED; // R11
         s_q.regs[`MSPS_IDX_RAMP]     <= `MSPS_RST_RAMP; // R2
         s_q.regs[`MSPS_IDX_IDLE]     <= `MSPS_RST_IDLE; // R3
         s_q.regs[`MSPS_IDX_DECEL1]   <= `MSPS_RST_DECEL; // R12
         s_q.regs[`MSPS_IDX_DECEL2]   <= `MSPS_RST_DECEL; // R12
         s_q.regs[`MSPS_IDX_TRIG]     <= `MSPS_RST_TRIG; // R4
         s_q.regs[`MSPS_IDX_NEXT]     <= `MSPS_RST_NEXT; // R9
         s_q.regs[`MSPS_IDX_SRC]      <= `MSPS_RST_SRC; // R10
         s_q.last_seg                 <= `MSPS_RST_LAST_SEG;
         s_q.state                    <= SQ_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready     = s_q.awready;
   assign s_axi_wready      = s_q.wready;
   assign s_axi_bvalid      = s_q.bvalid;
   assign s_axi_bresp       = s_q.bresp;
   assign s_axi_arready     = s_q.arready;
   assign s_axi_rvalid      = s_q.rvalid;
   assign s_axi_rdata       = s_q.rdata;
   assign s_axi_rresp       = s_q.rresp;
   assign cmd               = s_q.cmd;
   assign seq_busy          = s_q.busy;
   assign seq_halt          = s_q.halt;
   assign seq_finish        = s_q.finish;
   // Straight to the profile generator
   assign first_decel_time  = s_q.regs[`MSPS_IDX_DECEL1]; // R12
   assign second_decel_time = s_q.regs[`MSPS_IDX_DECEL2]; // R12
endmodule : msps_sequencer
`default_nettype wire

// ---- msps_sva.sv ----
/* Port checks of the sequencer; assumes binding into it, one clock. */
`timescale 1ns/100ps
`default_nettype none
module msps_sva (
   input wire logic                aclk, aresetn, ce,
   input wire logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic                s_axi_wready, s_axi_bvalid, s_axi_arvalid,
   input wire logic                s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [31:0]         s_axi_rdata,
   input wire msps_pkg::msps_cmd_t cmd,
   input wire logic                seq_busy, seq_halt, seq_finish,
   input wire logic [15:0]         first_decel_time, second_decel_time
);
   import msps_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   // Low ce freezes every flop
   default disable iff (!aresetn || !ce);
   sequence s_wr_hs;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_drop;
      seq_busy ##1 !seq_busy;
   endsequence
   a_write_resp: assert property (s_wr_hs |-> ##2 s_axi_bvalid)
      else $error("late write response");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read data");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_cmd_pulse: assert property (cmd.valid |=> !cmd.valid)
      else $error("command valid too long");
   a_cmd_busy: assert property (cmd.valid |-> seq_busy)
      else $error("command while idle");
   a_halt_idle: assert property (seq_halt |-> s_drop)
      else $error("halt without idle");
   a_finish_idle: assert property (seq_finish |-> s_drop)
      else $error("finish without idle");
   a_decel_reset: assert property ($rose(aresetn) |-> first_decel_time == 16'h01f4 && second_decel_time == 16'h01f4)
      else $error("wrong decel reset");
   a_seg_payload: assert property (cmd.valid && cmd.segment != 4'hf |-> cmd.position == 32'h0 && cmd.ramp == 16'h0)
      else $error("segment payload leaked");
endmodule : msps_sva
`default_nettype wire

// ---- msps_motion_model.sv ----
/* Motion model: done after done_delay cycles; assumes one clock. */
`timescale 1ns/100ps
`default_nettype none
module msps_motion_model (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire msps_pkg::msps_cmd_t cmd,
   input  wire logic [7:0]          done_delay,
   output logic                     segment_done
);
   import msps_pkg::*;
   logic [8:0] cnt_q;
   // A new command abandons the old move
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         segment_done <= 1'b0;
      end else begin
         segment_done <= (cnt_q == 9'd1);
         if (cmd.valid) cnt_q <= {1'b0, done_delay};
         else if (cnt_q != 9'd0) cnt_q <= cnt_q - 9'd1;
      end
   end
endmodule : msps_motion_model
`default_nettype wire

// ---- tb_top.sv ----
/* Sequencer bench; assumes the design, checker and motion model. */
`timescale 1ns/100ps
`default_nettype none
`include "msps_regs.svh"
module tb_top;
   import msps_pkg::*;
   logic           aclk = 0, aresetn = 0, ce = 1, s_axi_bready = 0, s_axi_rready = 0;
   logic           s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic           sequence_trigger_input = 0, idle_time_unit_tick = 0;
   logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic           s_axi_rvalid, segment_done, seq_busy, seq_halt, seq_finish;
   logic [7:0]     s_axi_awaddr = 0, s_axi_araddr = 0, done_delay = 8'h03;
   logic [31:0]    s_axi_wdata = 0, s_axi_rdata, rdat;
   logic [3:0]     s_axi_wstrb = 4'hf, digital_select_inputs = 0;
   logic [1:0]     s_axi_bresp, s_axi_rresp, rrsp;
   logic [15:0]    ext_idle_time = 16'h0001, first_decel_time, second_decel_time;
   msps_speed_in_t speed_in = '0;
   msps_cmd_t      cmd;
   int             fail_count = 0, samples_checked = 0, cyc = 0;
   localparam logic [7:0] OFS [9] = '{`MSPS_OFF_POS, `MSPS_OFF_SPEED, `MSPS_OFF_RAMP,
      `MSPS_OFF_IDLE, `MSPS_OFF_DECEL1, `MSPS_OFF_DECEL2, `MSPS_OFF_TRIG,
      `MSPS_OFF_NEXT, `MSPS_OFF_SRC};
   localparam logic [31:0] RST [9] = '{32'h2710, 32'h1f4, 32'h1f4, 32'h1, 32'h1f4,
      32'h1f4, 32'h1, 32'h0, 32'h0};
   localparam logic [31:0] WRV [9] = '{32'h8000_0000, 32'h8000, 32'hffff, 32'hffff,
      32'h0, 32'hffff, 32'h7, 32'h5, 32'h9};
   localparam logic [31:0] EXV [9] = '{32'h8000_0001, 32'h7fff, 32'hffff, 32'h7fff,
      32'h0, 32'hffff, 32'h3, 32'h1, 32'h4};
   msps_sequencer DUT (.*);
   msps_motion_model u_mot (.*);
   always #2 aclk = ~aclk;
   // One idle unit per four cycles keeps dwells short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      idle_time_unit_tick <= (cyc % 4 == 0);
      if (cyc == 20000) begin
         fail_count++;
         finish_test;
      end
   end
   task chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 0;
         end
      join
      s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      rrsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : rd
   task trg(input logic v);
      @(posedge aclk);
      sequence_trigger_input <= v;
   endtask : trg
   // Wait for cmd (0), halt (1) or finish (2); k > n: none came
   task wt(input int s, n, output int k);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while ((s == 0 ? cmd.valid : s == 1 ? seq_halt : seq_finish) !== 1'b1 && k <= n);
   endtask : wt
   task t_regs;
      chk("decel reset", {first_decel_time, second_decel_time}, 32'h01f4_01f4);
      for (int i = 0; i < 9; i++) begin
         rd(OFS[i]);
         chk("reset value", rdat, RST[i]);
         wr(OFS[i], WRV[i]);
         rd(OFS[i]);
         chk("limited value", rdat, EXV[i]);
      end
      chk("decel outputs", {first_decel_time, second_decel_time}, 32'h0000_ffff);
      rd(8'h3c);
      chk("unmapped resp", rrsp, 32'h2);
      wr(8'h3c, 32'h0);
      chk("bresp", rrsp, 32'h2);
      $display("Test registers done");
   endtask : t_regs
   task t_src;
      logic [15:0] e [5] = '{16'h1111, 16'h2222, 16'h3333, 16'h0, 16'h5555};
      int k;
      speed_in <= {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
      wr(`MSPS_OFF_CTRL, 32'h0);
      wr(`MSPS_OFF_TRIG, 32'h1);
      wr(`MSPS_OFF_NEXT, 32'h1);
      for (int s = 0; s < 5; s++) begin
         wr(`MSPS_OFF_SRC, 32'(s));
         trg(1);
         wt(0, 20, k);
         chk("first speed", {cmd.first, cmd.speed}, {1'b1, e[s]});
         wt(2, 40, k);
         chk("finish seen", k <= 40, 1'b1);
         trg(0);
         repeat (4) @(posedge aclk);
      end
      $display("Test source done");
   endtask : t_src
   task t_stop;
      int k;
      done_delay <= 8'd100;
      wr(`MSPS_OFF_NEXT, 32'h0);
      for (int b = 0; b < 2; b++) begin
         wr(`MSPS_OFF_TRIG, 32'(b));
         trg(1);
         wt(0, 20, k);
         trg(0);
         wt(1, 10, k);
         chk("halt on fall", k <= 10, b == 0);
         wt(2, 200, k);
         chk("finish after done", k > 80 && k <= 200, b == 1);
      end
      $display("Test stop done");
   endtask : t_stop
   task t_auto;
      int k;
      wr(`MSPS_OFF_CTRL, 32'h1);
      wr(`MSPS_OFF_POS, 32'hffff_fc18);
      wr(`MSPS_OFF_IDLE, 32'h2);
      wr(`MSPS_OFF_TRIG, 32'h1);
      wr(`MSPS_OFF_NEXT, 32'h1);
      digital_select_inputs <= 4'hf;
      wt(0, 20, k);
      chk("auto start", {k <= 20, cmd.segment}, 32'h1f);
      chk("seg16 position", cmd.position, 32'hffff_fc18);
      chk("seg16 ramp", cmd.ramp, 32'hffff);
      wt(2, 40, k);
      chk("seg16 dwell", k <= 40, 1'b1);
      wr(`MSPS_OFF_TRIG, 32'h3);
      digital_select_inputs <= 4'h5;
      wt(0, 20, k);
      chk("no auto start", k > 20, 1'b1);
      trg(1);
      wt(0, 20, k);
      chk("trigger start", {k <= 20, cmd.segment, cmd.position[3]}, 32'h2a);
      wt(2, 40, k);
      trg(0);
      $display("Test input start done");
   endtask : t_auto
   task t_next;
      int k;
      done_delay <= 8'd30;
      wr(`MSPS_OFF_CTRL, 32'h10);
      wr(`MSPS_OFF_TRIG, 32'h1);
      for (int n = 0; n < 2; n++) begin
         wr(`MSPS_OFF_NEXT, 32'(n));
         trg(1);
         wt(0, 20, k);
         wt(0, 80, k);
         chk("issue gap", k > 30 && k <= 80, n == 0);
         wt(2, 80, k);
         trg(0);
         repeat (4) @(posedge aclk);
      end
      $display("Test next done");
   endtask : t_next
   task finish_test;
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_src;
      t_stop;
      t_auto;
      t_next;
      finish_test;
   end
endmodule : tb_top
bind msps_sequencer msps_sva u_sva (.*);
`default_nettype wire
